// file: ebp_pkg.sv
// package: constants for the external bus pin controller
package ebp_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] ADDR_OFS    = 8'h08;
  localparam logic [7:0] WDATA_OFS   = 8'h0C;
  localparam logic [7:0] RDATA_OFS   = 8'h10;
  localparam logic [7:0] CCR_OFS     = 8'h14;
  // control register fields
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_WORD_BIT  = 2;
  localparam int CTRL_FETCH_BIT = 3;
  // configuration register fields
  localparam int CCR_BW_BIT     = 1;
  localparam int CCR_WRMODE_BIT = 2;
  localparam int CCR_ALE_BIT    = 3;
  localparam int CCR_IRC_LSB    = 4;
  localparam logic [7:0] CCR_RESET    = 8'h00;
  localparam logic [7:0] PSW_RESET    = 8'h00;
  // fixed addresses
  localparam logic [15:0] CCB_ADDR    = 16'h2018;
  localparam logic [15:0] START_ADDR  = 16'h2080;
  localparam logic [15:0] NMI_ADDR    = 16'h0000;
  localparam logic [15:0] ROM_LO      = 16'h2000;
  localparam logic [15:0] ROM_HI      = 16'h3FFF;
  // clock divider and timing
  localparam int CLK_DIV        = 3;
  localparam int STARTUP_STATES = 10;
  localparam int CLK_MHZ        = 10;
  localparam int MAX_CYCLE_NS   = 1000;
  localparam int MAX_CYCLE_CLKS = (MAX_CYCLE_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] ROM_RDATA_DEFAULT = 16'h0000;
  // bus sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE  = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DATA  = 3'b011,
    ST_WAIT  = 3'b100,
    ST_END   = 3'b101
  } ebp_state_type;
endpackage

// file: ebp_clkdiv.sv
// divide-by-three state clock with one-third duty and phase re-align
`timescale 1ns/1ps
module ebp_clkdiv (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // restart phase
  input  wire logic realign,
  // outputs
  output logic      clk_div_out,
  output logic      rise_en,
  output logic      fall_en
);
  logic [1:0] phase_reg;

  // phase counter 0..2, high only in phase 0
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
    end else if (realign || phase_reg == 2'(ebp_pkg::CLK_DIV - 1)) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // registered clock output and edge enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_div_out <= 1'b0;
      rise_en     <= 1'b0;
      fall_en     <= 1'b0;
    end else begin
      // realign restarts the count low, so no double-wide high phase
      clk_div_out <= !realign && phase_reg == 2'(ebp_pkg::CLK_DIV - 1);
      rise_en     <= !realign && phase_reg == 2'(ebp_pkg::CLK_DIV - 1);
      fall_en     <= !realign && phase_reg == 2'h0;
    end
  end
endmodule

// file: ebp_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module ebp_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // level in and out
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic meta_reg;

  // first flop only feeds the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule

// file: ebp_top.sv
// external bus pin controller with apb command and config port
`timescale 1ns/1ps
// Functional notes
// - state clock output runs at one third of sys_clk, one-third high
// - reset release re-aligns clock output and starts ten-state start-up
// - start-up clears status word, loads config from 2018H, jumps to 2080H
// - config bit 1 set: width pin picks 16 or 8 bit per cycle
// - config bit 1 clear: every external cycle is 8 bit
// - rising edge on nmi vectors execution to address 0000H
// - fetch indicator high for whole cycle of an instruction fetch read
// - rom select high sends 2000H-3FFFH on chip, low sends off chip
// - address strobe only on external cycles, in valid mode; latch mode config leaves it high
// - valid mode strobe returns high at end of each bus cycle
// - read strobe low only during external reads
// - write strobe every write, or only writes touching even byte
// - upper byte enable low selects high byte, both for word
// - high byte store strobe low on writes to odd address
// - ready low before falling edge stalls until rising edge with ready
// - ready ignored when no external access in progress
// - config field caps the number of wait states inserted
// - sixteen lines multiplex address and data, driven strongly
// - rom select latched at reset release, fixed until next reset
module ebp_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // device pins in
  input  wire logic        reset_n_pin,
  input  wire logic        bus_width_pin,
  input  wire logic        ready_pin,
  input  wire logic        nmi_pin,
  input  wire logic        internal_rom_select_pin,
  input  wire logic [15:0] ad_in,
  // device pins out
  output logic             divided_clock_output,
  output logic             address_valid_strobe,
  output logic             read_strobe_n,
  output logic             low_byte_store_strobe,
  output logic             high_byte_store_strobe,
  output logic             fetch_indicator,
  output logic [15:0]      ad_out,
  output logic [15:0]      ad_oe
);
  ebp_pkg::ebp_state_type state_reg;
  logic        rst_n_s, bw_s, rdy_s, nmi_s, rom_s;
  logic        nmi_prev_reg, rom_sel_reg, rst_n_prev_reg;
  logic        cd_rise, cd_fall, realign;
  logic [3:0]  startup_cnt_reg;
  logic        startup_reg, ccb_pending_reg;
  logic [7:0]  ccr_reg, psw_reg;
  logic [15:0] pc_reg, addr_reg, wdata_reg, rdata_reg;
  logic        go_reg, write_reg, word_reg, fetch_reg, busy_reg, wide_reg;
  logic        internal_reg, nmi_seen_reg, stalled_reg, overrun_reg;
  logic [1:0]  wait_cnt_reg;
  logic [3:0]  cyc_cnt_reg;
  logic        ext_hit, apb_wr, apb_rd;

  // pin synchronisers
  ebp_sync u_s_rst (.sys_clk(sys_clk), .rst(rst), .pin_in(reset_n_pin),
                    .pin_sync(rst_n_s));
  ebp_sync u_s_bw  (.sys_clk(sys_clk), .rst(rst), .pin_in(bus_width_pin),
                    .pin_sync(bw_s));
  ebp_sync u_s_rdy (.sys_clk(sys_clk), .rst(rst), .pin_in(ready_pin),
                    .pin_sync(rdy_s));
  ebp_sync u_s_nmi (.sys_clk(sys_clk), .rst(rst), .pin_in(nmi_pin),
                    .pin_sync(nmi_s));
  ebp_sync u_s_rom (.sys_clk(sys_clk), .rst(rst),
                    .pin_in(internal_rom_select_pin), .pin_sync(rom_s));

  // release edge of the device reset pin
  assign realign = rst_n_s && !rst_n_prev_reg;

  // state clock generator
  ebp_clkdiv u_div (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .realign     (realign),
    .clk_div_out (divided_clock_output),
    .rise_en     (cd_rise),
    .fall_en     (cd_fall)
  );

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // previous levels for edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_n_prev_reg <= 1'b0;
      nmi_prev_reg   <= 1'b0;
    end else begin
      rst_n_prev_reg <= rst_n_s;
      nmi_prev_reg   <= nmi_s;
    end
  end

  // rom select caught at reset-pin release only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rom_sel_reg <= 1'b0;
    end else if (realign) begin
      rom_sel_reg <= rom_s;
    end
  end

  // start-up sequencer counts ten state times after release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      startup_reg     <= 1'b1;
      startup_cnt_reg <= 4'h0;
      psw_reg         <= ebp_pkg::PSW_RESET;
    end else if (!rst_n_s) begin
      startup_reg     <= 1'b1;
      startup_cnt_reg <= 4'h0;
    end else if (realign) begin
      startup_cnt_reg <= 4'h0;
      psw_reg         <= ebp_pkg::PSW_RESET;
    end else if (startup_reg && cd_rise) begin
      if (startup_cnt_reg == 4'(ebp_pkg::STARTUP_STATES - 1)) begin
        startup_reg <= 1'b0;
      end
      startup_cnt_reg <= startup_cnt_reg + 4'h1;
    end
  end

  // program counter: start address, nmi vector or bus progress
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_reg       <= ebp_pkg::START_ADDR;
      nmi_seen_reg <= 1'b0;
    end else if (startup_reg) begin
      pc_reg       <= ebp_pkg::START_ADDR;
      nmi_seen_reg <= 1'b0;
    end else if (nmi_s && !nmi_prev_reg) begin
      pc_reg       <= ebp_pkg::NMI_ADDR;
      nmi_seen_reg <= 1'b1;
    end else if (busy_reg && fetch_reg && state_reg == ebp_pkg::ST_END) begin
      pc_reg <= pc_reg + (wide_reg ? 16'h0002 : 16'h0001);
    end
  end

  // rom window decode, with the latched select
  assign ext_hit = !(rom_sel_reg && addr_reg >= ebp_pkg::ROM_LO &&
                     addr_reg <= ebp_pkg::ROM_HI);

  // apb-written command and data registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      go_reg    <= 1'b0;
      write_reg <= 1'b0;
      word_reg  <= 1'b0;
      fetch_reg <= 1'b0;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
    end else if (startup_reg) begin
      go_reg    <= ccb_pending_reg;
      write_reg <= 1'b0;
      word_reg  <= 1'b0;
      fetch_reg <= 1'b0;
      addr_reg  <= ebp_pkg::CCB_ADDR;
    end else begin
      // drop go only on the edge where the sequencer takes it
      if (go_reg && cd_rise && state_reg == ebp_pkg::ST_IDLE) begin
        go_reg <= 1'b0;
      end
      if (apb_wr && paddr == ebp_pkg::CTRL_OFS && !busy_reg) begin
        go_reg    <= pwdata[ebp_pkg::CTRL_GO_BIT];
        write_reg <= pwdata[ebp_pkg::CTRL_WRITE_BIT];
        word_reg  <= pwdata[ebp_pkg::CTRL_WORD_BIT];
        fetch_reg <= pwdata[ebp_pkg::CTRL_FETCH_BIT];
        if (pwdata[ebp_pkg::CTRL_FETCH_BIT]) begin
          addr_reg <= pc_reg;
        end
      end
      if (apb_wr && paddr == ebp_pkg::ADDR_OFS && !busy_reg) begin
        addr_reg <= pwdata[15:0];
      end
      if (apb_wr && paddr == ebp_pkg::WDATA_OFS && !busy_reg) begin
        wdata_reg <= pwdata[15:0];
      end
    end
  end

  // configuration register: loaded by start-up read, also apb writable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ccr_reg         <= ebp_pkg::CCR_RESET;
      ccb_pending_reg <= 1'b1;
    end else if (!rst_n_s) begin
      ccb_pending_reg <= 1'b1;
    end else if (startup_reg && ccb_pending_reg &&
                 state_reg == ebp_pkg::ST_END) begin
      ccr_reg         <= rdata_reg[7:0];
      ccb_pending_reg <= 1'b0;
    end else if (apb_wr && paddr == ebp_pkg::CCR_OFS) begin
      ccr_reg <= pwdata[7:0];
    end
  end

  // bus sequencer, stepped on state-clock edges
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ebp_pkg::ST_RESET;
      busy_reg     <= 1'b0;
      wide_reg     <= 1'b0;
      internal_reg <= 1'b0;
      stalled_reg  <= 1'b0;
      wait_cnt_reg <= 2'h0;
      rdata_reg    <= 16'h0000;
    end else if (!rst_n_s) begin
      state_reg <= ebp_pkg::ST_RESET;
      busy_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        ebp_pkg::ST_RESET: begin
          if (realign) begin
            state_reg <= ebp_pkg::ST_IDLE;
          end
        end
        ebp_pkg::ST_IDLE: begin
          if (go_reg && cd_rise) begin
            busy_reg     <= 1'b1;
            internal_reg <= !ext_hit;
            // width chosen per cycle when dynamic sizing enabled
            wide_reg     <= ccr_reg[ebp_pkg::CCR_BW_BIT] && bw_s;
            stalled_reg  <= 1'b0;
            wait_cnt_reg <= 2'h0;
            state_reg    <= ebp_pkg::ST_ADDR;
          end
        end
        ebp_pkg::ST_ADDR: begin
          if (cd_rise) begin
            state_reg <= ebp_pkg::ST_DATA;
          end
        end
        ebp_pkg::ST_DATA: begin
          // ready sampled before the falling edge, external only
          if (cd_fall && !internal_reg && !rdy_s &&
              wait_cnt_reg != ccr_reg[ebp_pkg::CCR_IRC_LSB +: 2]) begin
            stalled_reg <= 1'b1;
          end
          if (cd_rise) begin
            if (stalled_reg) begin
              state_reg <= ebp_pkg::ST_WAIT;
            end else begin
              state_reg <= ebp_pkg::ST_END;
              rdata_reg <= internal_reg ? ebp_pkg::ROM_RDATA_DEFAULT : ad_in;
            end
          end
        end
        ebp_pkg::ST_WAIT: begin
          // one wait state per state time until ready or cap reached
          if (cd_rise) begin
            wait_cnt_reg <= wait_cnt_reg + 2'h1;
            if (rdy_s || wait_cnt_reg + 2'h1 ==
                ccr_reg[ebp_pkg::CCR_IRC_LSB +: 2]) begin
              state_reg <= ebp_pkg::ST_END;
              rdata_reg <= ad_in;
            end
          end
        end
        ebp_pkg::ST_END: begin
          busy_reg  <= 1'b0;
          state_reg <= ebp_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= ebp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // watchdog on cycle length, flags overrun past one microsecond
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cyc_cnt_reg <= 4'h0;
      overrun_reg <= 1'b0;
    end else if (!busy_reg) begin
      cyc_cnt_reg <= 4'h0;
    end else if (cyc_cnt_reg == 4'(ebp_pkg::MAX_CYCLE_CLKS)) begin
      overrun_reg <= 1'b1;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
    end
  end

  // pin outputs, registered, idle levels high for active-low strobes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      address_valid_strobe   <= 1'b1;
      read_strobe_n          <= 1'b1;
      low_byte_store_strobe  <= 1'b1;
      high_byte_store_strobe <= 1'b1;
      fetch_indicator        <= 1'b0;
      ad_out                 <= 16'h0000;
      ad_oe                  <= 16'h0000;
    end else begin
      address_valid_strobe   <= 1'b1;
      read_strobe_n          <= 1'b1;
      low_byte_store_strobe  <= 1'b1;
      high_byte_store_strobe <= 1'b1;
      fetch_indicator        <= 1'b0;
      ad_oe                  <= 16'h0000;
      if (busy_reg && !internal_reg && state_reg != ebp_pkg::ST_END) begin
        fetch_indicator <= fetch_reg && !write_reg;
        if (state_reg == ebp_pkg::ST_ADDR) begin
          // latch mode stays high as at idle, valid mode holds low all cycle
          address_valid_strobe <= ccr_reg[ebp_pkg::CCR_ALE_BIT]
                                  ? 1'b1 : 1'b0;
          ad_out <= addr_reg;
          ad_oe  <= 16'hFFFF;
        end else begin
          address_valid_strobe <= !ccr_reg[ebp_pkg::CCR_ALE_BIT]
                                  ? 1'b0 : 1'b1;
          if (write_reg) begin
            ad_out <= wdata_reg;
            ad_oe  <= wide_reg ? 16'hFFFF : 16'h00FF;
            low_byte_store_strobe <= ccr_reg[ebp_pkg::CCR_WRMODE_BIT]
              ? addr_reg[0] : 1'b0;
            high_byte_store_strobe <= ccr_reg[ebp_pkg::CCR_WRMODE_BIT]
              ? !(addr_reg[0] || (word_reg && wide_reg))
              : !(addr_reg[0] || word_reg);
          end else begin
            read_strobe_n <= 1'b0;
            high_byte_store_strobe <= ccr_reg[ebp_pkg::CCR_WRMODE_BIT]
              ? 1'b1 : !(addr_reg[0] || word_reg);
          end
        end
      end
    end
  end

  // apb slave: zero wait states, error on unmapped offsets
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          ebp_pkg::CTRL_OFS:   prdata <= {28'h0, fetch_reg, word_reg,
                                          write_reg, go_reg};
          ebp_pkg::STATUS_OFS: prdata <= {psw_reg, 16'h0, 1'b0,
                                          nmi_seen_reg, overrun_reg,
                                          rom_sel_reg, wide_reg,
                                          internal_reg, startup_reg,
                                          busy_reg};
          ebp_pkg::ADDR_OFS:   prdata <= {pc_reg, addr_reg};
          ebp_pkg::WDATA_OFS:  prdata <= {16'h0, wdata_reg};
          ebp_pkg::RDATA_OFS:  prdata <= {16'h0, rdata_reg};
          ebp_pkg::CCR_OFS:    prdata <= {24'h0, ccr_reg};
          default:             pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

// file: ebp_top_properties.sv
// checker: port-level properties of the bus pin controller
`timescale 1ns/1ps
module ebp_top_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // bus pins
  input wire logic        divided_clock_output,
  input wire logic        read_strobe_n,
  input wire logic        low_byte_store_strobe,
  input wire logic        fetch_indicator,
  input wire logic [15:0] ad_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] low_cnt;
  // length of the current strobe-low stretch, saturating
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 4'h0;
    end else if (read_strobe_n && low_byte_store_strobe) begin
      low_cnt <= 4'h0;
    end else if (low_cnt != 4'hF) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end
  // a read opens with lines released after a driven address
  sequence s_rd_open;
    $fell(read_strobe_n);
  endsequence
  sequence s_rd_data;
    !read_strobe_n && ad_oe == 16'h0000;
  endsequence
  a_clk_high_one: assert property (
    divided_clock_output |=> !divided_clock_output)
    else $error("clock output high too long");
  a_clk_low_two: assert property (
    $rose(divided_clock_output) |=> !divided_clock_output [*2])
    else $error("clock output low phase too short");
  a_reset_quiet: assert property (
    $fell(rst) |-> read_strobe_n && low_byte_store_strobe && ad_oe == 16'h0)
    else $error("bus active right after reset");
  a_read_release: assert property (
    !read_strobe_n |-> s_rd_data)
    else $error("lines driven during read");
  a_addr_first: assert property (
    s_rd_open |-> $past(ad_oe) == 16'hFFFF)
    else $error("read without address phase");
  a_write_drive: assert property (
    !low_byte_store_strobe |-> ad_oe[7:0] == 8'hFF)
    else $error("write data not driven");
  a_rd_wr_apart: assert property (
    !read_strobe_n |-> low_byte_store_strobe)
    else $error("read and write strobes together");
  a_strobe_bound: assert property (
    low_cnt <= 4'hC)
    else $error("strobe held beyond wait cap");
  a_fetch_hold: assert property (
    $fell(fetch_indicator) |-> read_strobe_n)
    else $error("fetch flag dropped mid read");
endmodule

bind ebp_top ebp_top_props i_ebp_top_props (
  .sys_clk(sys_clk), .rst(rst),
  .divided_clock_output(divided_clock_output),
  .read_strobe_n(read_strobe_n),
  .low_byte_store_strobe(low_byte_store_strobe),
  .fetch_indicator(fetch_indicator), .ad_oe(ad_oe)
);

// file: ebp_mem.sv
// model: external memory on the multiplexed bus
`timescale 1ns/1ps
module ebp_mem (
  // clock
  input  wire logic        sys_clk,
  // device bus pins
  input  wire logic        address_valid_strobe,
  input  wire logic        read_strobe_n,
  input  wire logic        low_byte_store_strobe,
  input  wire logic        high_byte_store_strobe,
  input  wire logic        fetch_indicator,
  input  wire logic [15:0] ad_out,
  input  wire logic [15:0] ad_oe,
  // answers to the device
  output logic [15:0]      ad_in = 16'h5A5A,
  output logic             ready_pin = 1'b1,
  // wait cycles per read
  input  wire logic [3:0]  stall_len
);
  logic [15:0] mem [logic [15:0]];
  logic [15:0] addr_q [$];
  logic [15:0] cur_addr = 16'h0, last_wr = 16'h0;
  logic        got = 1'b0, rd_prev = 1'b1;
  logic        seen_lo = 1'b0, seen_hi = 1'b0, seen_fetch = 1'b0;
  logic [3:0]  stall_cnt = 4'h0;
  int          rd_count = 0, rd_len = 0;
  // config byte: byte strobes, dynamic width, two wait states
  initial mem[ebp_pkg::CCB_ADDR] = 16'h0026;
  // address capture, strobe records, stalls and read data
  always @(posedge sys_clk) begin
    if (address_valid_strobe) begin
      got = 1'b0;
    end else if (!got && ad_oe == 16'hFFFF && read_strobe_n
                 && low_byte_store_strobe) begin
      got = 1'b1;
      cur_addr = ad_out;
      addr_q.push_back(ad_out);
    end
    if (!read_strobe_n && rd_prev) begin
      rd_count++;
      rd_len = 0;
      stall_cnt = stall_len;
    end
    if (!read_strobe_n) rd_len++;
    if (!read_strobe_n && fetch_indicator) seen_fetch = 1'b1;
    if (!low_byte_store_strobe) seen_lo = 1'b1;
    if (!high_byte_store_strobe) seen_hi = 1'b1;
    if (!low_byte_store_strobe || !high_byte_store_strobe) last_wr = ad_out;
    // held low ahead of a slow read so it stands before the falling edge
    ready_pin <= read_strobe_n ? (stall_len == 4'h0) : (stall_cnt == 4'h0);
    if (stall_cnt != 4'h0) stall_cnt--;
    // released lines toggle so stale data never passes as an answer
    if (!read_strobe_n) begin
      ad_in <= mem.exists(cur_addr) ? mem[cur_addr] : 16'h0;
    end else begin
      ad_in <= ~ad_in;
    end
    rd_prev = read_strobe_n;
  end
endmodule

// file: ebp_top_tb.sv
// testbench: bus pin controller against a memory model
`timescale 1ns/1ps
module ebp_top_tb;
  logic        sys_clk = 1'b0, rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, err_q, reset_n_pin = 1'b0;
  logic        bus_width_pin = 1'b1, nmi_pin = 1'b0, rom_sel = 1'b0;
  logic        ready_pin, avs, rd_n, lo_n, hi_n, fetch, clk3;
  logic [15:0] ad_in, ad_out, ad_oe;
  logic [3:0]  stall_len = 4'h0;
  int          err_total = 0, cmp_count = 0, cyc = 0;

  ebp_top i_ebp_top (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_n_pin(reset_n_pin),
    .bus_width_pin(bus_width_pin), .ready_pin(ready_pin),
    .nmi_pin(nmi_pin), .internal_rom_select_pin(rom_sel), .ad_in(ad_in),
    .divided_clock_output(clk3), .address_valid_strobe(avs),
    .read_strobe_n(rd_n), .low_byte_store_strobe(lo_n),
    .high_byte_store_strobe(hi_n), .fetch_indicator(fetch),
    .ad_out(ad_out), .ad_oe(ad_oe)
  );
  ebp_mem i_ebp_mem (
    .sys_clk(sys_clk), .address_valid_strobe(avs), .read_strobe_n(rd_n),
    .low_byte_store_strobe(lo_n), .high_byte_store_strobe(hi_n),
    .fetch_indicator(fetch), .ad_out(ad_out), .ad_oe(ad_oe),
    .ad_in(ad_in), .ready_pin(ready_pin), .stall_len(stall_len)
  );

  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  // watchdog on the whole run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  // one apb transfer; answer lands in rd_q and err_q
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the given flag clears
  task automatic poll(input int b);
    rd_q = '1;
    for (int i = 0; i < 80 && rd_q[b] !== 1'b0; i++)
      apb(1'b0, ebp_pkg::STATUS_OFS, 32'h0);
  endtask
  // one bus cycle: pc field mirrors the address
  task automatic run(input logic [15:0] a, w, input logic [3:0] c);
    apb(1'b1, ebp_pkg::ADDR_OFS, {a, a});
    apb(1'b1, ebp_pkg::WDATA_OFS, {16'h0, w});
    apb(1'b1, ebp_pkg::CTRL_OFS, {28'h0, c});
    // let the sequencer take go before busy is polled
    repeat (3) @(posedge sys_clk);
    poll(0);
  endtask
  task automatic do_reset(input logic rom);
    rst <= 1'b1;
    reset_n_pin <= 1'b0;
    rom_sel <= rom;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    poll(1);
  endtask
  task automatic t_startup();
    apb(1'b0, ebp_pkg::STATUS_OFS, 32'h0);
    chk("status word", 32'h0, {24'h0, rd_q[31:24]});
    apb(1'b0, ebp_pkg::CCR_OFS, 32'h0);
    chk("config", 32'h26, {24'h0, rd_q[7:0]});
    chk("boot addr", 32'h2018, {16'h0, i_ebp_mem.addr_q[0]});
    apb(1'b0, ebp_pkg::ADDR_OFS, 32'h0);
    chk("start pc", 32'h2080, {16'h0, rd_q[31:16]});
    $display("test startup done");
  endtask
  task automatic t_width();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ebp_pkg::CCR_OFS, (i == 2) ? 32'h24 : 32'h26);
      bus_width_pin <= (i != 1);
      i_ebp_mem.seen_lo = 1'b0;
      run(16'h0100, 16'hC3A5, 4'h7);
      chk("wide", {31'h0, i == 0}, {31'h0, rd_q[3]});
      chk("store", 32'h1, {31'h0, i_ebp_mem.seen_lo});
      if (i == 0) chk("word", 32'hC3A5, {16'h0, i_ebp_mem.last_wr});
    end
    $display("test width done");
  endtask
  task automatic t_bytes();
    apb(1'b1, ebp_pkg::CCR_OFS, 32'h26);
    for (int i = 0; i < 2; i++) begin
      i_ebp_mem.seen_lo = 1'b0;
      i_ebp_mem.seen_hi = 1'b0;
      run(i ? 16'h0102 : 16'h0101, 16'h005A, 4'h3);
      chk("low store", {31'h0, i == 1}, {31'h0, i_ebp_mem.seen_lo});
      chk("high store", {31'h0, i == 0}, {31'h0, i_ebp_mem.seen_hi});
    end
    $display("test bytes done");
  endtask
  task automatic t_fetch();
    i_ebp_mem.mem[16'h0200] = 16'h1234;
    // a fetch reads from the program counter, still at the start address
    i_ebp_mem.mem[16'h2080] = 16'h1234;
    for (int i = 0; i < 2; i++) begin
      i_ebp_mem.seen_fetch = 1'b0;
      run(16'h0200, 16'h0, i ? 4'h5 : 4'hD);
      chk("fetch", {31'h0, i == 0}, {31'h0, i_ebp_mem.seen_fetch});
      apb(1'b0, ebp_pkg::RDATA_OFS, 32'h0);
      chk("rdata", 32'h1234, {16'h0, rd_q[15:0]});
    end
    $display("test fetch done");
  endtask
  task automatic t_stall();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ebp_pkg::CCR_OFS, (i == 2) ? 32'h06 : 32'h26);
      stall_len <= (i == 0) ? 4'h0 : 4'h6;
      run(16'h0200, 16'h0, 4'h5);
      if (i == 1) chk("stall", 32'h1, {31'h0, i_ebp_mem.rd_len > 3});
      else chk("rd length", 32'h3, i_ebp_mem.rd_len);
    end
    stall_len <= 4'h0;
    $display("test stall done");
  endtask
  task automatic t_misc();
    nmi_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    nmi_pin <= 1'b0;
    apb(1'b0, ebp_pkg::STATUS_OFS, 32'h0);
    chk("nmi", 32'h1, {31'h0, rd_q[6]});
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err_q});
    $display("test misc done");
  endtask
  task automatic t_rom();
    int n;
    rom_sel <= 1'b1;
    n = i_ebp_mem.rd_count;
    run(16'h2100, 16'h0, 4'h5);
    chk("latched sel", n + 1, i_ebp_mem.rd_count);
    do_reset(1'b1);
    n = i_ebp_mem.rd_count;
    run(16'h2100, 16'h0, 4'h5);
    chk("on chip", n, i_ebp_mem.rd_count);
    apb(1'b0, ebp_pkg::RDATA_OFS, 32'h0);
    chk("rom data", 32'h0, {16'h0, rd_q[15:0]});
    $display("test rom done");
  endtask

  // main sequence
  initial begin
    do_reset(1'b0);
    t_startup();
    t_width();
    t_bytes();
    t_fetch();
    t_stall();
    t_misc();
    t_rom();
    test_done();
  end
endmodule
